// ### design/adcct_ctrl.sv
/*
 * Control logic of an 8-bit successive-approximation converter:
 * APB registers, conversion sequencer, compare-unit trigger handling,
 * timer clear strobe and done interrupt.
 * Assumes a comparator output that is synchronous to mclk and a
 * special event trigger that comes as a pulse on mclk.
 */
// Notes on behaviour
// - Any reset turns the converter off and aborts a running conversion.
// - Reset leaves the result register alone; its power-up value is unknown.
// - An enabled trigger sets go/done and starts converting the selected channel.
// - Every trigger in special event mode clears the period timer counter to zero.
// - Unpowered converter ignores triggers; the timer is still cleared.
// - Hold capacitor disconnects one bit period after go, one instruction cycle later with the RC clock; channel may change then.
// - On completion go/done clears and the done flag sets.
// - Result loads in the same cycle that go/done clears.
`timescale 1ns/1ps
`include "adcct_map.svh"
`default_nettype none

module adcct_ctrl #(
    parameter int RESULT_W = 8,
    parameter int CNT_W    = 8
) (
    input  wire logic                mclk,
    input  wire logic                arst_n,
    input  wire logic [7:0]          paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                trigIn,
    input  wire logic [3:0]          compareModeSelect,
    input  wire logic                sleepIn,
    input  wire logic                cmpIn,
    output logic                     timerClear,
    output logic                     holdConnect,
    output logic      [2:0]          muxChan,
    output logic      [RESULT_W-1:0] dacCode,
    output logic                     analogEnable,
    output logic                     irq
);

    // Bit index counts down from the MSB to zero
    localparam int IDX_W = $clog2(RESULT_W);

    generate
        if (RESULT_W < 2 || RESULT_W > 16) begin : g_bad_width
            $error("RESULT_W must lie between 2 and 16");
        end
        if ((1 << CNT_W) <= `ADCCT_RC_TAD_CYC ||
            (1 << CNT_W) <= `ADCCT_INSTR_CYC  ||
            (1 << CNT_W) <= `ADCCT_TAD_32TOSC) begin : g_bad_cnt
            $error("CNT_W too narrow for the bit period");
        end
        if ((1 << IDX_W) < `ADCCT_WAIT_TADS) begin : g_bad_wait
            $error("Bit index too narrow for the closing wait");
        end
    endgenerate

    adcct_pkg::adcct_state_t  state_q;
    adcct_pkg::adcct_state_t  state_d;
    adcct_pkg::adcct_clksrc_t clkSrc_q;

    logic                  powerOn_q;
    logic [2:0]            chan_q;
    logic                  go_q;
    logic [`ADCCT_ST_W-1:0] status_q;
    logic [`ADCCT_ST_W-1:0] mask_q;
    logic [RESULT_W-1:0]   result_q;
    logic [RESULT_W-1:0]   code_q;
    logic [RESULT_W-1:0]   codeStep;
    logic [CNT_W-1:0]      cnt_q;
    logic [CNT_W-1:0]      cnt_d;
    logic [IDX_W-1:0]      bitIdx_q;
    logic [IDX_W-1:0]      bitIdx_d;
    logic                  trigPrev_q;
    logic                  timerClear_q;
    logic [31:0]           prdata_q;

    // Zero wait states; every access ends in its first access cycle
    // Bus decode
    wire access   = psel & penable;
    wire setupRd  = psel & ~penable & ~pwrite;
    wire selCtrl  = (paddr == `ADCCT_CTRL_OFS);
    wire selSt    = (paddr == `ADCCT_STATUS_OFS);
    wire selMask  = (paddr == `ADCCT_MASK_OFS);
    wire selRes   = (paddr == `ADCCT_RESULT_OFS);
    wire hit      = selCtrl | selSt | selMask | selRes;
    wire wrEn     = access & pwrite;
    wire wrCtrl   = wrEn & selCtrl;
    wire wrSt     = wrEn & selSt;
    wire wrMask   = wrEn & selMask;
    wire wrRes    = wrEn & selRes;

    assign pready  = 1'b1;
    assign pslverr = access & ~hit;
    assign prdata  = prdata_q;

    // State decode
    wire inIdle  = (state_q == adcct_pkg::S_IDLE);
    wire inDelay = (state_q == adcct_pkg::S_DELAY);
    wire inHold  = (state_q == adcct_pkg::S_HOLD);
    wire inConv  = (state_q == adcct_pkg::S_CONV);
    wire inWait  = (state_q == adcct_pkg::S_WAIT);
    wire busy    = inDelay | inHold | inConv;

    // Trigger path; edge detect so a stretched pulse starts once
    wire trigPulse   = trigIn & ~trigPrev_q;
    wire trigValid   = trigPulse &
                       (compareModeSelect == `ADCCT_SPECIAL_EVT);
    wire trigStart   = trigValid & powerOn_q;
    wire trigIgnored = trigValid & ~powerOn_q;

    // Software go and abort
    // Power and go in one write do not start: the input must settle first
    wire wrGo      = pwdata[`ADCCT_CTRL_GO_BIT];
    wire wrOn      = pwdata[`ADCCT_CTRL_ON_BIT];
    wire swStart   = wrCtrl & wrGo & powerOn_q;
    wire startReq  = (swStart | trigStart) & inIdle;
    wire swAbort   = wrCtrl & (~wrGo | ~wrOn);
    // A sleep aborts unless the RC clock keeps the sequencer running
    wire sleepKill = sleepIn & (clkSrc_q != adcct_pkg::CLK_RC);
    wire abortReq  = busy & (swAbort | sleepKill | ~powerOn_q);

    // Bit period from the selected clock source
    wire [CNT_W-1:0] tadLen =
        (clkSrc_q == adcct_pkg::CLK_2TOSC)  ? CNT_W'(`ADCCT_TAD_2TOSC)  :
        (clkSrc_q == adcct_pkg::CLK_8TOSC)  ? CNT_W'(`ADCCT_TAD_8TOSC)  :
        (clkSrc_q == adcct_pkg::CLK_32TOSC) ? CNT_W'(`ADCCT_TAD_32TOSC) :
                                              CNT_W'(`ADCCT_RC_TAD_CYC);
    wire [CNT_W-1:0] instrLen = CNT_W'(`ADCCT_INSTR_CYC);
    wire             tadEnd   = (cnt_q == '0);
    wire             lastBit  = (bitIdx_q == '0);
    wire             convDone = inConv & tadEnd & lastBit & ~abortReq;

    // One SAR step per bit: keep or drop the trial bit, try the next
    genvar gi;
    generate
        for (gi = 0; gi < RESULT_W; gi++) begin : g_sar
            if (gi + 1 < RESULT_W) begin : g_low
                assign codeStep[gi] =
                    (bitIdx_q == IDX_W'(gi))     ? cmpIn :
                    (bitIdx_q == IDX_W'(gi + 1)) ? 1'b1  :
                                                   code_q[gi];
            end else begin : g_top
                // No higher bit hands a trial to the top bit; an index
                // one past it would wrap onto the last step's index
                assign codeStep[gi] =
                    (bitIdx_q == IDX_W'(gi)) ? cmpIn : code_q[gi];
            end
        end
    endgenerate

    // Sequencer
    always_comb begin
        state_d  = state_q;
        bitIdx_d = bitIdx_q;
        unique case (state_q)
            adcct_pkg::S_IDLE: begin
                if (startReq) begin
                    // RC clock: one instruction cycle lets sleep begin
                    if (clkSrc_q == adcct_pkg::CLK_RC) begin
                        state_d = adcct_pkg::S_DELAY;
                    end else begin
                        state_d = adcct_pkg::S_HOLD;
                    end
                end
            end
            adcct_pkg::S_DELAY: begin
                if (abortReq) begin
                    state_d  = adcct_pkg::S_WAIT;
                    bitIdx_d = IDX_W'(`ADCCT_WAIT_TADS - 1);
                end else if (tadEnd) begin
                    state_d = adcct_pkg::S_HOLD;
                end
            end
            adcct_pkg::S_HOLD: begin
                if (abortReq) begin
                    state_d  = adcct_pkg::S_WAIT;
                    bitIdx_d = IDX_W'(`ADCCT_WAIT_TADS - 1);
                end else if (tadEnd) begin
                    state_d  = adcct_pkg::S_CONV;
                    bitIdx_d = IDX_W'(RESULT_W - 1);
                end
            end
            adcct_pkg::S_CONV: begin
                if (abortReq) begin
                    state_d  = adcct_pkg::S_WAIT;
                    bitIdx_d = IDX_W'(`ADCCT_WAIT_TADS - 1);
                end else if (tadEnd) begin
                    if (lastBit) begin
                        state_d  = adcct_pkg::S_WAIT;
                        bitIdx_d = IDX_W'(`ADCCT_WAIT_TADS - 1);
                    end else begin
                        bitIdx_d = bitIdx_q - 1'b1;
                    end
                end
            end
            adcct_pkg::S_WAIT: begin
                // Starts are refused until the closing wait is over
                if (tadEnd) begin
                    if (lastBit) begin
                        state_d = adcct_pkg::S_IDLE;
                    end else begin
                        bitIdx_d = bitIdx_q - 1'b1;
                    end
                end
            end
        endcase
    end

    // Reload on every period end and on every state change
    wire reload = tadEnd | (state_d != state_q);
    always_comb begin
        if (!reload) begin
            cnt_d = cnt_q - 1'b1;
        end else if (state_d == adcct_pkg::S_DELAY) begin
            cnt_d = instrLen - 1'b1;
        end else begin
            cnt_d = tadLen - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q  <= adcct_pkg::S_IDLE;
            cnt_q    <= '0;
            bitIdx_q <= '0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            bitIdx_q <= bitIdx_d;
        end
    end

    // Trial code driven to the DAC
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            code_q <= '0;
        end else if (state_d == adcct_pkg::S_CONV && !inConv) begin
            code_q <= RESULT_W'(1) << (RESULT_W - 1);
        end else if (inConv && tadEnd) begin
            code_q <= codeStep;
        end
    end

    // Control register; go is set by hardware and cleared at the end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            powerOn_q <= 1'b0;
            chan_q    <= `ADCCT_CHAN_RST;
            clkSrc_q  <= adcct_pkg::CLK_2TOSC;
            go_q      <= 1'b0;
        end else begin
            if (wrCtrl) begin
                powerOn_q <= wrOn;
                chan_q    <= pwdata[`ADCCT_CTRL_CHAN_MSB:`ADCCT_CTRL_CHAN_LSB];
                clkSrc_q  <= adcct_pkg::adcct_clksrc_t'(
                    pwdata[`ADCCT_CTRL_CLK_MSB:`ADCCT_CTRL_CLK_LSB]);
            end
            if (startReq) begin
                go_q <= 1'b1;
            end else if (convDone || abortReq) begin
                go_q <= 1'b0;
            end
        end
    end

    // An abort never reaches convDone, so the last good result stays
    // Result: no reset so a reset keeps the last conversion
    always_ff @(posedge mclk) begin
        if (convDone) begin
            result_q <= codeStep;
        end else if (wrRes) begin
            result_q <= pwdata[RESULT_W-1:0];
        end
    end

    // Sticky status, write one to clear; a new event wins over a clear
    wire [`ADCCT_ST_W-1:0] stEvents = {trigIgnored, trigStart, convDone};
    wire [`ADCCT_ST_W-1:0] stClear  =
        wrSt ? pwdata[`ADCCT_ST_W-1:0] : '0;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= '0;
            mask_q   <= `ADCCT_MASK_RST;
        end else begin
            status_q <= (status_q & ~stClear) | stEvents;
            if (wrMask) begin
                mask_q <= pwdata[`ADCCT_ST_W-1:0];
            end
        end
    end

    assign irq = |(status_q & mask_q);

    // Timer clear goes out for every valid trigger, powered or not
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            trigPrev_q   <= 1'b0;
            timerClear_q <= 1'b0;
        end else begin
            trigPrev_q   <= trigIn;
            timerClear_q <= trigValid;
        end
    end

    assign timerClear = timerClear_q;

    // Unmapped reads return zero; pslverr tells the master why
    // Read data latched in the setup phase so it leaves a flip-flop
    wire [31:0] rdCtrl = {25'h0, go_q, clkSrc_q, chan_q, powerOn_q};
    wire [31:0] rdMux  =
        selCtrl ? rdCtrl :
        selSt   ? {{(32 - `ADCCT_ST_W){1'b0}}, status_q} :
        selMask ? {{(32 - `ADCCT_ST_W){1'b0}}, mask_q} :
        selRes  ? {{(32 - RESULT_W){1'b0}}, result_q} :
                  32'h0;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_q <= '0;
        end else if (setupRd) begin
            prdata_q <= rdMux;
        end
    end

    // Analog side; the capacitor follows the input until the
    // first bit period ends, after which the channel may change
    assign holdConnect  = powerOn_q & (inIdle | inDelay | inHold);
    assign muxChan      = chan_q;
    assign dacCode      = code_q;
    // Powered down in sleep while idle or in the closing wait, though the enable bit stays set
    assign analogEnable = powerOn_q & ~(sleepIn & (inIdle | inWait));

endmodule // adcct_ctrl

`default_nettype wire

// ### design/adcct_map.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * for the converter trigger control block.
 * Assumes a 10 MHz device clock and a 32-bit APB register bus.
 */
`ifndef ADCCT_MAP_SVH
`define ADCCT_MAP_SVH

`define ADCCT_CTRL_OFS      8'h00
`define ADCCT_STATUS_OFS    8'h04
`define ADCCT_MASK_OFS      8'h08
`define ADCCT_RESULT_OFS    8'h0c

`define ADCCT_CTRL_ON_BIT   0
`define ADCCT_CTRL_CHAN_LSB 1
`define ADCCT_CTRL_CHAN_MSB 3
`define ADCCT_CTRL_CLK_LSB  4
`define ADCCT_CTRL_CLK_MSB  5
`define ADCCT_CTRL_GO_BIT   6

`define ADCCT_ST_DONE_BIT   0
`define ADCCT_ST_TRIG_BIT   1
`define ADCCT_ST_IGN_BIT    2
`define ADCCT_ST_W          3

`define ADCCT_CHAN_RST      3'h0
`define ADCCT_CLK_RST       2'h0
`define ADCCT_MASK_RST      3'h0

`define ADCCT_SPECIAL_EVT   4'hb

`define ADCCT_CLK_NS        100
`define ADCCT_RC_TAD_NS     6000
`define ADCCT_RC_TAD_CYC    ((`ADCCT_RC_TAD_NS + `ADCCT_CLK_NS - 1) / `ADCCT_CLK_NS)
`define ADCCT_INSTR_NS      400
`define ADCCT_INSTR_CYC     ((`ADCCT_INSTR_NS + `ADCCT_CLK_NS - 1) / `ADCCT_CLK_NS)
`define ADCCT_TAD_2TOSC     2
`define ADCCT_TAD_8TOSC     8
`define ADCCT_TAD_32TOSC    32
`define ADCCT_WAIT_TADS     2

`endif

// ### design/adcct_pkg.sv
/*
 * Types for the converter trigger control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package adcct_pkg;

    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_DELAY = 5'b00010,
        S_HOLD  = 5'b00100,
        S_CONV  = 5'b01000,
        S_WAIT  = 5'b10000
    } adcct_state_t;

    typedef enum logic [1:0] {
        CLK_2TOSC  = 2'h0,
        CLK_8TOSC  = 2'h1,
        CLK_32TOSC = 2'h2,
        CLK_RC     = 2'h3
    } adcct_clksrc_t;

endpackage

// ### verification/adcct_ctrl_props.sv
/* Port checker for adcct_ctrl: trigger, timer clear, hold and APB.
   Assumes one mclk domain and the trigger partner on trigIn. */
`timescale 1ns/1ps
`default_nettype none
module adcct_ctrl_props #(
    parameter int RESULT_W = 8
) (
    input wire logic                mclk,
    input wire logic                arst_n,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic                trigIn,
    input wire logic [3:0]          compareModeSelect,
    input wire logic                timerClear,
    input wire logic                holdConnect,
    input wire logic [RESULT_W-1:0] dacCode,
    input wire logic                analogEnable,
    input wire logic                irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    property p_trig_clear;
        $rose(trigIn) && compareModeSelect == 4'hb |=> timerClear;
    endproperty
    a_trig_clear: assert property (p_trig_clear) else $error("no clear");
    property p_mode_gate;
        $rose(trigIn) && compareModeSelect != 4'hb |=> !timerClear;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("bad mode");
    property p_clear_once;
        timerClear |=> !timerClear;
    endproperty
    a_clear_once: assert property (p_clear_once) else $error("long");
    property p_clear_cause;
        timerClear |-> $past(trigIn) && !$past(trigIn, 2);
    endproperty
    a_clear_cause: assert property (p_clear_cause) else $error("cause");
    property p_rst_off;
        $rose(arst_n) |-> !analogEnable && !holdConnect && !irq;
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("not off");
    property p_start;
        $rose(trigIn) && compareModeSelect == 4'hb && holdConnect
            && analogEnable |-> ##[1:80] !holdConnect;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_ignore;
        $rose(trigIn) && !holdConnect && !analogEnable
            |=> !holdConnect && !analogEnable;
    endproperty
    a_ignore: assert property (p_ignore) else $error("started");
    property p_msb_first;
        $fell(holdConnect) && analogEnable
            |-> dacCode == {1'b1, {(RESULT_W-1){1'b0}}};
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("msb");
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("wait state");
    property p_err;
        pslverr |-> psel && penable;
    endproperty
    a_err: assert property (p_err) else $error("stray error");

    c_trig: cover property ($rose(trigIn) && holdConnect);
    c_err: cover property (pslverr);
    c_irq: cover property ($rose(irq));
endmodule // adcct_ctrl_props

bind adcct_ctrl adcct_ctrl_props #(.RESULT_W(RESULT_W)) uProps (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .trigIn(trigIn),
    .compareModeSelect(compareModeSelect), .timerClear(timerClear),
    .holdConnect(holdConnect), .dacCode(dacCode),
    .analogEnable(analogEnable), .irq(irq)
);
`default_nettype wire

// ### verification/adcct_far_model.sv
/* Compare unit, period timer and analog input with sample and hold.
   Assumes fire is held for exactly one mclk cycle by the bench. */
`timescale 1ns/1ps
`default_nettype none
module adcct_far_model (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic       fire,
    input  wire logic [3:0] modeSet,
    input  wire logic       timerClear,
    input  wire logic       holdConnect,
    input  wire logic [2:0] muxChan,
    input  wire logic [7:0] dacCode,
    output logic            trigIn,
    output logic      [3:0] compareModeSelect,
    output logic            cmpIn,
    output logic      [15:0] timerCnt
);
    logic [7:0] heldQ;
    // Each channel has its own level so a wrong channel shows in the result
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            trigIn <= 1'b0;
            compareModeSelect <= 4'h0;
            timerCnt <= 16'h0;
            heldQ <= 8'h0;
        end else begin
            trigIn <= fire;
            compareModeSelect <= modeSet;
            timerCnt <= timerClear ? 16'h0 : timerCnt + 16'h1;
            if (holdConnect) begin
                heldQ <= {muxChan, 5'h0d};
            end
        end
    end
    assign cmpIn = (heldQ >= dacCode);
endmodule // adcct_far_model
`default_nettype wire

// ### verification/tb_adcct_ctrl.sv
/* Self-checking bench for adcct_ctrl with the far-side model.
   Assumes the register map and timing of the package headers. */
`timescale 1ns/1ps
`default_nettype none
module tb_adcct_ctrl;
    logic mclk, arst_n, psel, penable, pwrite, fire, slvErr;
    logic pready, pslverr, trigIn, cmpIn, timerClear, holdConnect;
    logic analogEnable, irq, sleepIn;
    logic [7:0]  paddr, dacCode;
    logic [31:0] pwdata, prdata, rd, ctl;
    logic [3:0]  modeSet, compareModeSelect;
    logic [2:0]  muxChan;
    logic [15:0] timerCnt;
    int          errTotal = 0, nCompared = 0, cycles = 0;

    adcct_ctrl uut (
        .mclk(mclk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trigIn(trigIn), .compareModeSelect(compareModeSelect),
        .sleepIn(sleepIn), .cmpIn(cmpIn), .timerClear(timerClear),
        .holdConnect(holdConnect), .muxChan(muxChan), .dacCode(dacCode),
        .analogEnable(analogEnable), .irq(irq)
    );
    adcct_far_model far (
        .mclk(mclk), .arst_n(arst_n), .fire(fire), .modeSet(modeSet),
        .timerClear(timerClear), .holdConnect(holdConnect),
        .muxChan(muxChan), .dacCode(dacCode), .trigIn(trigIn),
        .compareModeSelect(compareModeSelect), .cmpIn(cmpIn),
        .timerCnt(timerCnt)
    );

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic giveVerdict();
        $display("compared %0d mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errTotal++;
            giveVerdict();
        end
    end

    task automatic chk(input logic [32:0] exp, input logic [32:0] got);
        nCompared++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk({1'b0, exp}, {slvErr, rd});
    endtask

    // Done is polled through go; the trailing wait covers the 2 TAD pause
    task automatic waitDone();
        bus(1'b0, 8'h00, 32'h0);
        while (rd[6] === 1'b1) bus(1'b0, 8'h00, 32'h0);
        repeat (130) @(posedge mclk);
    endtask

    task automatic pulse();
        repeat (50) @(posedge mclk);
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    task automatic tReset();
        rdChk(8'h00, 32'h0);
        rdChk(8'h04, 32'h0);
        rdChk(8'h08, 32'h0);
        bus(1'b1, 8'h0c, 32'ha5);
        rdChk(8'h0c, 32'ha5);
        bus(1'b1, 8'h10, 32'h1);
        chk(33'h1, {32'h0, slvErr});
        bus(1'b0, 8'h10, 32'h0);
        chk(33'h100000000, {slvErr, rd});
    endtask

    task automatic tSoft();
        for (int s = 0; s < 4; s++) begin
            ctl = {26'h0, s[1:0], 3'(s + 1), 1'b1};
            bus(1'b1, 8'h00, ctl);
            repeat (50) @(posedge mclk);
            bus(1'b1, 8'h00, ctl | 32'h40);
            waitDone();
            rdChk(8'h0c, {24'h0, 3'(s + 1), 5'h0d});
            rdChk(8'h00, ctl);
            rdChk(8'h04, 32'h1);
            bus(1'b1, 8'h04, 32'h7);
        end
    endtask

    task automatic tTrig();
        bus(1'b1, 8'h00, 32'h5);
        pulse();
        chk(33'h1, {32'h0, timerCnt > 16'h8});
        rdChk(8'h00, 32'h5);
        modeSet <= 4'hb;
        pulse();
        chk(33'h1, {32'h0, timerCnt < 16'h8});
        rdChk(8'h00, 32'h45);
        bus(1'b1, 8'h00, 32'h4b);
        waitDone();
        rdChk(8'h0c, 32'h4d);
        rdChk(8'h04, 32'h3);
        bus(1'b1, 8'h08, 32'h2);
        chk(33'h1, {32'h0, irq});
        bus(1'b1, 8'h04, 32'h2);
        chk(33'h0, {32'h0, irq});
        bus(1'b1, 8'h04, 32'h7);
    endtask

    task automatic tOff();
        bus(1'b1, 8'h00, 32'h0);
        pulse();
        chk(33'h1, {32'h0, timerCnt < 16'h8});
        rdChk(8'h00, 32'h0);
        rdChk(8'h04, 32'h4);
        bus(1'b1, 8'h04, 32'h7);
    endtask

    task automatic tAbort();
        bus(1'b1, 8'h00, 32'h3);
        repeat (50) @(posedge mclk);
        bus(1'b1, 8'h00, 32'h43);
        repeat (6) @(posedge mclk);
        bus(1'b1, 8'h00, 32'h3);
        repeat (130) @(posedge mclk);
        rdChk(8'h0c, 32'h4d);
        rdChk(8'h04, 32'h0);
        bus(1'b1, 8'h00, 32'h43);
        repeat (6) @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rdChk(8'h00, 32'h0);
        rdChk(8'h0c, 32'h4d);
    endtask

    // RC clock survives sleep; any other bit clock is aborted by it
    task automatic tSleep();
        bus(1'b1, 8'h00, 32'h37);
        repeat (50) @(posedge mclk);
        bus(1'b1, 8'h00, 32'h77);
        sleepIn <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(33'h1, {32'h0, analogEnable});
        waitDone();
        chk(33'h0, {32'h0, analogEnable});
        rdChk(8'h0c, 32'h6d);
        rdChk(8'h04, 32'h1);
        bus(1'b1, 8'h04, 32'h7);
        sleepIn <= 1'b0;
        bus(1'b1, 8'h00, 32'h3);
        repeat (50) @(posedge mclk);
        bus(1'b1, 8'h00, 32'h43);
        sleepIn <= 1'b1;
        repeat (130) @(posedge mclk);
        chk(33'h0, {32'h0, analogEnable});
        rdChk(8'h00, 32'h3);
        rdChk(8'h04, 32'h0);
        rdChk(8'h0c, 32'h6d);
        sleepIn <= 1'b0;
    endtask

    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fire = 1'b0;
        sleepIn = 1'b0;
        modeSet = 4'h0;
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        tReset();
        tSoft();
        tTrig();
        tOff();
        tAbort();
        tSleep();
        giveVerdict();
    end
endmodule // tb_adcct_ctrl
`default_nettype wire
